// [rtl/ddc_ctrl.sv]
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ddc_ctrl #(
	parameter int unsigned INIT_WAIT_CYC = ddc_pkg::INIT_CYC
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic               clk_en,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	output logic                    ddr_ck,
	output logic                    ddr_ck_n,
	output logic                    ddr_cke,
	output ddc_pkg::ddc_pins_t      ddr_pins,
	input  wire logic [15:0]        ddr_dq_i,
	output logic      [15:0]        ddr_dq_o,
	output logic                    ddr_dq_oe,
	output logic      [1:0]         ddr_dm,
	input  wire logic               ddr_dqs_i,
	output logic                    ddr_dqs_o,
	output logic                    ddr_dqs_oe
);
	import ddc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		I_WAIT, I_CKE, I_PRE1, I_EMRS, I_MRS_RST, I_PRE2, I_REF1, I_REF2, I_MRS, I_DONE
	} ddc_init_t;

	typedef struct packed {
		logic [1:0]      ph;
		logic            ck;
		logic            ck_n;
		logic            cke;
		ddc_pins_t       pins;
		ddc_init_t       init;
		logic [15:0]     cnt;
		logic [7:0]      gap;
		logic [3:0]      open;
		logic [3:0][3:0] blk;
		logic            pd;
		logic            sr;
		logic            err;
		logic            pend;
		logic [6:0]      cmd;
		logic [12:0]     addr;
		logic [31:0]     wdata;
		logic [3:0]      wmask;
		logic [12:0]     mode;
		logic [12:0]     emode;
		logic [2:0]      wseq;
		logic            wap;
		logic [1:0]      wbank;
		logic            rd_pend;
		logic            rd_done;
		logic            rd_rise;
		logic            dqs_prev;
		logic [31:0]     rbuf;
		logic [31:0]     rdata;
		logic [15:0]     dq_o;
		logic            dq_oe;
		logic [1:0]      dm;
		logic            dqs_o;
		logic            dqs_oe;
	} ddc_st_t;

	ddc_st_t    s_r;
	ddc_st_t    s_nxt;
	logic [15:0] dq_s;
	logic        dqs_s;

	ddc_sync3 #(.W(16)) u_sync_dq (
		.clk (sys_clk),
		.rst (rst),
		.ce  (clk_en),
		.d   (ddr_dq_i),
		.q   (dq_s)
	);

	ddc_sync3 #(.W(1)) u_sync_dqs (
		.clk (sys_clk),
		.rst (rst),
		.ce  (clk_en),
		.d   (ddr_dqs_i),
		.q   (dqs_s)
	);

	function automatic ddc_pins_t pins_f(input logic [3:0] ctl, input logic [1:0] ba, input logic [12:0] a);
		pins_f = '{ctl: ctl, ba: ba, a: a};
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       tick;
		logic [3:0] code;
		logic [1:0] bank;
		logic       ap;
		tick  = (s_r.ph == 2'h1);
		code  = s_r.cmd[3:0];
		bank  = s_r.cmd[5:4];
		ap    = s_r.cmd[6];
		s_nxt = s_r;
		s_nxt.ph    = s_r.ph + 2'h1;
		s_nxt.ck    = ~s_nxt.ph[1];
		s_nxt.ck_n  = s_nxt.ph[1];
		s_nxt.rdata = '0;

		if (reg_wr) begin
			case (reg_addr)
				OFS_CMD: begin
					s_nxt.cmd  = reg_wdata[6:0];
					s_nxt.pend = 1'b1;
				end
				OFS_ADDR:   s_nxt.addr  = reg_wdata[12:0];
				OFS_WDATA:  s_nxt.wdata = reg_wdata;
				OFS_WMASK:  s_nxt.wmask = reg_wdata[3:0];
				OFS_MODE:   s_nxt.mode  = reg_wdata[12:0];
				OFS_EMODE:  s_nxt.emode = reg_wdata[12:0];
				OFS_STATUS: begin
					if (reg_wdata[ST_ERR]) s_nxt.err = 1'b0;
					if (reg_wdata[ST_RDONE]) s_nxt.rd_done = 1'b0;
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CMD:    s_nxt.rdata = {25'h0, s_r.cmd};
				OFS_ADDR:   s_nxt.rdata = {19'h0, s_r.addr};
				OFS_WDATA:  s_nxt.rdata = s_r.wdata;
				OFS_WMASK:  s_nxt.rdata = {28'h0, s_r.wmask};
				OFS_MODE:   s_nxt.rdata = {19'h0, s_r.mode};
				OFS_EMODE:  s_nxt.rdata = {19'h0, s_r.emode};
				OFS_STATUS: s_nxt.rdata = {20'h0, s_r.open, 1'b0, (s_r.wseq != 3'h0), s_r.rd_done,
					s_r.sr, s_r.pd, s_r.err, s_r.pend, (s_r.init == I_DONE)};
				OFS_RDATA:  s_nxt.rdata = s_r.rbuf;
				default:    s_nxt.rdata = '0;
			endcase
		end

		// read capture on synchronised strobe edges
		s_nxt.dqs_prev = dqs_s;
		if (s_r.rd_pend && dqs_s && !s_r.dqs_prev) begin
			s_nxt.rbuf[15:0] = dq_s;
			s_nxt.rd_rise    = 1'b1;
		end
		// a strobe left high by the last burst must not pass for the second beat
		if (s_r.rd_pend && s_r.rd_rise && !dqs_s && s_r.dqs_prev) begin
			s_nxt.rbuf[31:16] = dq_s;
			s_nxt.rd_rise     = 1'b0;
			s_nxt.rd_pend     = 1'b0;
			s_nxt.rd_done     = 1'b1;
		end

		// write burst of two beats, data centred on the strobe edges
		if (s_r.wseq != 3'h0) begin
			s_nxt.wseq = s_r.wseq + 3'h1;
			case (s_r.wseq)
				3'h1: begin
					s_nxt.dqs_oe = 1'b1;
					s_nxt.dqs_o  = 1'b0;
				end
				3'h2: begin
					s_nxt.dq_oe = 1'b1;
					s_nxt.dq_o  = s_r.wdata[15:0];
					s_nxt.dm    = s_r.wmask[1:0];
				end
				3'h3: s_nxt.dqs_o = 1'b1;
				3'h4: begin
					s_nxt.dq_o = s_r.wdata[31:16];
					s_nxt.dm   = s_r.wmask[3:2];
				end
				3'h5: s_nxt.dqs_o = 1'b0;
				3'h6: begin
					s_nxt.dq_oe = 1'b0;
					s_nxt.dm    = 2'h0;
				end
				default: begin
					s_nxt.dqs_oe = 1'b0;
					s_nxt.wseq   = 3'h0;
					if (s_r.wap) s_nxt.blk[s_r.wbank] = BLK_DAL;
				end
			endcase
		end

		if (s_r.init == I_WAIT && s_r.cnt != 16'hffff) begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
		end

		// command slot: one per link clock, changed while the link clock is low
		if (tick) begin
			s_nxt.pins.ctl = s_r.cke ? P_NOP : s_r.pins.ctl;
			if (!s_r.cke && !s_r.sr) s_nxt.pins.ctl = (s_r.init == I_DONE) ? P_NOP : P_DESEL;
			for (int b = 0; b < 4; b++) begin
				if (s_r.blk[b] != 4'h0) s_nxt.blk[b] = s_r.blk[b] - 4'h1;
			end
			if (s_r.gap != 8'h00) begin
				s_nxt.gap = s_r.gap - 8'h01;
			end else begin
				case (s_r.init)
					I_WAIT: begin
						if (32'(s_r.cnt) >= INIT_WAIT_CYC - 1) s_nxt.init = I_CKE;
					end
					I_CKE: begin
						s_nxt.pins = pins_f(P_NOP, 2'h0, 13'h0000);
						s_nxt.cke  = 1'b1;
						s_nxt.init = I_PRE1;
					end
					I_PRE1, I_PRE2: begin
						s_nxt.pins = pins_f(P_PRE, 2'h0, 13'h0400);
						s_nxt.gap  = GAP_RP;
						s_nxt.open = 4'h0;
						s_nxt.init = (s_r.init == I_PRE1) ? I_EMRS : I_REF1;
					end
					I_EMRS: begin
						s_nxt.pins = pins_f(P_MRS, 2'h1, s_r.emode);
						s_nxt.gap  = GAP_MRD;
						s_nxt.init = I_MRS_RST;
					end
					I_MRS_RST: begin
						s_nxt.pins = pins_f(P_MRS, 2'h0, s_r.mode);
						s_nxt.pins.a[DLLR_BIT] = 1'b1;
						s_nxt.gap  = GAP_DLL;
						s_nxt.init = I_PRE2;
					end
					I_REF1, I_REF2: begin
						s_nxt.pins = pins_f(P_REF, 2'h0, 13'h0000);
						s_nxt.gap  = GAP_REF;
						s_nxt.init = (s_r.init == I_REF1) ? I_REF2 : I_MRS;
					end
					I_MRS: begin
						s_nxt.pins = pins_f(P_MRS, 2'h0, s_r.mode);
						s_nxt.pins.a[DLLR_BIT] = 1'b0;
						s_nxt.gap  = GAP_MRD;
						s_nxt.init = I_DONE;
					end
					I_DONE: begin
						if (s_r.pend) begin
							// a new command written in this cycle stays pending
							if (!(reg_wr && reg_addr == OFS_CMD)) s_nxt.pend = 1'b0;
							if (s_r.pd || s_r.sr) begin
								if (code == C_EXIT) begin
									s_nxt.pins = pins_f(P_NOP, 2'h0, 13'h0000);
									s_nxt.cke  = 1'b1;
									s_nxt.pd   = 1'b0;
									s_nxt.sr   = 1'b0;
									if (s_r.sr) s_nxt.gap = GAP_DLL;
								end else begin
									s_nxt.err = 1'b1;
								end
							end else begin
								case (code)
									C_NOP: s_nxt.pins = pins_f(P_NOP, 2'h0, 13'h0000);
									C_ACT: begin
										if (!s_r.open[bank] && s_r.blk[bank] == 4'h0) begin
											s_nxt.pins = pins_f(P_ACT, bank, s_r.addr);
											s_nxt.open[bank] = 1'b1;
										end else begin
											s_nxt.err = 1'b1;
										end
									end
									C_RD, C_WR: begin
										if (s_r.open[bank] && s_r.wseq == 3'h0 && !s_r.rd_pend) begin
											s_nxt.pins = pins_f((code == C_WR) ? P_WR : P_RD, bank, s_r.addr);
											s_nxt.pins.a[AP_BIT] = ap;
											if (ap) s_nxt.open[bank] = 1'b0;
											if (code == C_WR) begin
												s_nxt.wseq  = 3'h1;
												s_nxt.wap   = ap;
												s_nxt.wbank = bank;
											end else begin
												s_nxt.rd_pend = 1'b1;
												s_nxt.rd_rise = 1'b0;
												if (ap) s_nxt.blk[bank] = BLK_DAL;
											end
										end else begin
											s_nxt.err = 1'b1;
										end
									end
									C_PRE: begin
										s_nxt.pins = pins_f(P_PRE, bank, 13'h0000);
										s_nxt.pins.a[AP_BIT] = ap;
										if (ap) s_nxt.open = 4'h0;
										else s_nxt.open[bank] = 1'b0;
										for (int b = 0; b < 4; b++) begin
											if (ap || bank == 2'(b)) s_nxt.blk[b] = BLK_RP;
										end
									end
									C_REF, C_SREF: begin
										if (s_r.open == 4'h0) begin
											s_nxt.pins = pins_f(P_REF, 2'h0, 13'h0000);
											s_nxt.gap  = GAP_REF;
											if (code == C_SREF) begin
												s_nxt.cke = 1'b0;
												s_nxt.sr  = 1'b1;
											end
										end else begin
											s_nxt.err = 1'b1;
										end
									end
									C_PD: begin
										s_nxt.pins = pins_f(P_NOP, 2'h0, 13'h0000);
										s_nxt.cke  = 1'b0;
										s_nxt.pd   = 1'b1;
									end
									C_BST: s_nxt.pins = pins_f(P_BST, 2'h0, 13'h0000);
									C_MRS, C_EMRS: begin
										if (s_r.open == 4'h0 && s_r.wseq == 3'h0) begin
											s_nxt.pins = pins_f(P_MRS, {1'b0, code == C_EMRS},
												(code == C_EMRS) ? s_r.emode : s_r.mode);
											s_nxt.gap  = GAP_MRD;
										end else begin
											s_nxt.err = 1'b1;
										end
									end
									default: s_nxt.err = 1'b1;
								endcase
							end
						end
					end
					default: s_nxt.init = I_WAIT;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r      <= '0;
			s_r.pins <= PINS_RST;
			s_r.ck_n <= 1'b1;
			s_r.init <= I_WAIT;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata  = s_r.rdata;
	assign ddr_ck     = s_r.ck;
	assign ddr_ck_n   = s_r.ck_n;
	assign ddr_cke    = s_r.cke;
	assign ddr_pins   = s_r.pins;
	assign ddr_dq_o   = s_r.dq_o;
	assign ddr_dq_oe  = s_r.dq_oe;
	assign ddr_dm     = s_r.dm;
	assign ddr_dqs_o  = s_r.dqs_o;
	assign ddr_dqs_oe = s_r.dqs_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic mrs_on;
	logic ref_on;
	logic act_on;
	logic rw_on;
	assign mrs_on = (s_r.pins.ctl == P_MRS);
	assign ref_on = (s_r.pins.ctl == P_REF);
	assign act_on = (s_r.pins.ctl == P_ACT);
	assign rw_on  = (s_r.pins.ctl == P_RD) || (s_r.pins.ctl == P_WR);

	a_cke_low_wait: assert property ((s_r.init == I_WAIT) |-> (!ddr_cke && !ddr_dq_oe))
		else $error("clock enable or data driven during power-up wait");
	a_mrs_gap_nop: assert property ((clk_en && $rose(mrs_on)) |-> ##4 (!clk_en || ddr_pins.ctl == P_NOP))
		else $error("command issued too soon after mode write");
	a_mrs_banks_idle: assert property ($rose(mrs_on) |-> (s_r.open == 4'h0))
		else $error("mode write with an open bank");
	a_ref_banks_idle: assert property ($rose(ref_on) |-> (s_r.open == 4'h0))
		else $error("refresh with an open bank");
	a_no_rw_wap: assert property ((s_r.wseq != 3'h0 && s_r.wap) |=> !$rose(rw_on))
		else $error("read or write during auto-precharge write");
	// the reset write itself still stands while the gap holds its first value
	a_dll_wait_nop: assert property ((s_r.init == I_PRE2 && s_r.gap != 8'h00 && s_r.gap != GAP_DLL) |->
		(ddr_pins.ctl == P_NOP))
		else $error("command during loop reset wait");
	a_cke_pre_all: assert property ($rose(s_r.pins.ctl == P_PRE) && s_r.init != I_DONE |-> ddr_cke)
		else $error("precharge all before clock enable raised");
	a_act_blocked: assert property ($rose(act_on) |-> (s_r.blk[ddr_pins.ba] == 4'h0))
		else $error("activate inside precharge period");
	a_final_mrs_dll: assert property ((s_r.init == I_DONE && $past(s_r.init) == I_MRS) |-> !ddr_pins.a[DLLR_BIT])
		else $error("final mode write still resets the loop");
endmodule // ddc_ctrl
`default_nettype wire

// [pkg/ddc_pkg.sv]
`default_nettype none
package ddc_pkg;

	// ----------------------------------------------------------------
	// clocking and timing
	// ----------------------------------------------------------------
	localparam int SYS_NS     = 20;
	localparam int CK_DIV     = 4;
	localparam int CK_NS      = SYS_NS * CK_DIV;
	localparam int TRP_NS     = 15;
	localparam int TWR_NS     = 15;
	localparam int TRP_CK     = (TRP_NS + CK_NS - 1) / CK_NS;
	localparam int TWR_CK     = (TWR_NS + CK_NS - 1) / CK_NS;
	localparam int TDAL_CK    = TWR_CK + TRP_CK;
	localparam int TMRD_CK    = 2;
	localparam int DLL_CK     = 200;
	localparam int REF_GAP_CK = 8;
	localparam int INIT_US    = 200;
	localparam int INIT_CYC   = (INIT_US * 1000 + SYS_NS - 1) / SYS_NS;

	localparam logic [7:0] GAP_RP   = 8'(TRP_CK - 1);
	localparam logic [7:0] GAP_MRD  = 8'(TMRD_CK - 1);
	localparam logic [7:0] GAP_DLL  = 8'(DLL_CK - 1);
	localparam logic [7:0] GAP_REF  = 8'(REF_GAP_CK - 1);
	localparam logic [3:0] BLK_DAL  = 4'(TDAL_CK);
	localparam logic [3:0] BLK_RP   = 4'(TRP_CK);

	// ----------------------------------------------------------------
	// pin encodings {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [3:0] P_DESEL = 4'hf;
	localparam logic [3:0] P_NOP   = 4'h7;
	localparam logic [3:0] P_MRS   = 4'h0;
	localparam logic [3:0] P_REF   = 4'h1;
	localparam logic [3:0] P_PRE   = 4'h2;
	localparam logic [3:0] P_ACT   = 4'h3;
	localparam logic [3:0] P_WR    = 4'h4;
	localparam logic [3:0] P_RD    = 4'h5;
	localparam logic [3:0] P_BST   = 4'h6;
	localparam int         AP_BIT  = 10;
	localparam int         DLLR_BIT = 8;

	// ----------------------------------------------------------------
	// software commands and register map
	// ----------------------------------------------------------------
	localparam logic [3:0] C_NOP  = 4'h0;
	localparam logic [3:0] C_ACT  = 4'h1;
	localparam logic [3:0] C_RD   = 4'h2;
	localparam logic [3:0] C_WR   = 4'h3;
	localparam logic [3:0] C_PRE  = 4'h4;
	localparam logic [3:0] C_REF  = 4'h5;
	localparam logic [3:0] C_SREF = 4'h6;
	localparam logic [3:0] C_PD   = 4'h7;
	localparam logic [3:0] C_EXIT = 4'h8;
	localparam logic [3:0] C_BST  = 4'h9;
	localparam logic [3:0] C_MRS  = 4'ha;
	localparam logic [3:0] C_EMRS = 4'hb;

	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_WMASK  = 8'h0c;
	localparam logic [7:0] OFS_MODE   = 8'h10;
	localparam logic [7:0] OFS_EMODE  = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_RDATA  = 8'h1c;
	localparam int         ST_ERR     = 2;
	localparam int         ST_RDONE   = 5;

	typedef struct packed {
		logic [3:0]  ctl;
		logic [1:0]  ba;
		logic [12:0] a;
	} ddc_pins_t;

	localparam ddc_pins_t PINS_RST = '{ctl: P_DESEL, ba: 2'h0, a: 13'h0000};

endpackage
`default_nettype wire

// [rtl/ddc_sync3.sv]
`timescale 1ns/10ps
`default_nettype none
module ddc_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ddc_sync_st_t;

	ddc_sync_st_t s_r;
	ddc_sync_st_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		// only a level seen twice counts, so a sample caught mid-edge is ignored
		if (s_r.s2 == s_r.s3) begin
			s_nxt.q = s_r.s3;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule // ddc_sync3
`default_nettype wire

// [testbench/ddc_dram_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ddc_dram_model (
	input  wire logic               ck,
	input  wire logic               cke,
	input  wire ddc_pkg::ddc_pins_t pins,
	input  wire logic [15:0]        dq_o,
	input  wire logic               dq_oe,
	input  wire logic [1:0]         dm,
	input  wire logic               dqs_o,
	input  wire logic               dqs_oe,
	output logic      [15:0]        dq_i,
	output logic                    dqs_i
);
	import ddc_pkg::*;
	int         viol   = 0;
	int         since  = 0;
	int         need   = 0;
	logic [3:0] open_q = 4'h0;
	logic       cke_q  = 1'b0;
	logic       pd     = 1'b0;
	logic       sr     = 1'b0;
	logic [1:0] wbank  = 2'h0;
	logic       wbeat  = 1'b0;
	logic [15:0] mem [4][2] = '{default: 16'h0000};
	ddc_pins_t  log_q [$];

	// idle data lines: no pull, so a fixed pattern; strobe low until first read
	initial begin
		dq_i = 16'h5a5a;
		dqs_i = 1'b0;
	end

	// ----------------------------------------------------------------
	// command decode at clock rise
	// ----------------------------------------------------------------
	always @(posedge ck) begin
		since = since + 1;
		if (cke_q && !cke) begin
			if (pins.ctl == P_REF)
				sr = 1'b1;
			else
				pd = 1'b1;
		end else if (!cke_q && cke) begin
			pd = 1'b0;
			sr = 1'b0;
		end else if (cke && !pins.ctl[3] && pins.ctl != P_NOP) begin
			if (since < need)
				viol++;
			log_q.push_back(pins);
			since = 0;
			need = 1;
			case (pins.ctl)
				P_MRS: begin
					if (open_q != 4'h0)
						viol++;
					need = (pins.ba == 2'h0 && pins.a[DLLR_BIT]) ? DLL_CK : TMRD_CK;
				end
				P_REF: if (open_q != 4'h0) viol++;
				P_ACT: begin
					if (open_q[pins.ba])
						viol++;
					open_q[pins.ba] = 1'b1;
				end
				P_PRE: if (pins.a[AP_BIT]) open_q = 4'h0; else open_q[pins.ba] = 1'b0;
				P_WR: begin
					if (!open_q[pins.ba])
						viol++;
					wbank = pins.ba;
					wbeat = 1'b0;
					if (pins.a[AP_BIT])
						open_q[pins.ba] = 1'b0;
				end
				P_RD: begin
					if (!open_q[pins.ba])
						viol++;
					fork
						rd_burst(pins.ba);
					join_none
					if (pins.a[AP_BIT])
						open_q[pins.ba] = 1'b0;
				end
				default: ;
			endcase
		end
		cke_q = cke;
	end

	// masked bytes keep old contents, mask taken with the same strobe edge
	always @(posedge dqs_o or negedge dqs_o) begin
		if (dqs_oe) begin
			if (!dq_oe)
				viol++;
			if (!dm[0])
				mem[wbank][wbeat][7:0] = dq_o[7:0];
			if (!dm[1])
				mem[wbank][wbeat][15:8] = dq_o[15:8];
			wbeat = ~wbeat;
		end
	end

	// slow strobe: the controller synchronises dq and dqs
	task automatic rd_burst(input logic [1:0] b);
		// off the controller's clock edges
		#205;
		dq_i = mem[b][0];
		dqs_i = 1'b0;
		#80;
		dqs_i = 1'b1;
		#80;
		dq_i = mem[b][1];
		#80;
		dqs_i = 1'b0;
		#80;
		dq_i = ~mem[b][1];
		#2000;
		dqs_i = 1'b1;
	endtask
endmodule // ddc_dram_model
`default_nettype wire

// [testbench/ddc_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ddc_ctrl_tb_top;
	import ddc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, rv, wdat;
	logic        ck, ck_n, cke, dq_oe, dqs_i, dqs_o, dqs_oe;
	logic [15:0] dq_i, dq_o, e0, e1;
	logic [1:0]  dm, bank;
	logic [3:0]  wmsk;
	logic [12:0] mode_v, emode_v, row;
	ddc_pins_t   pins, pv;
	ddc_pins_t   exp_a [7];
	logic [3:0]  bad [3] = '{C_ACT, C_MRS, C_REF};
	int          miscompares = 0;
	int          comparisons = 0;
	int          idx, n0;

	always #10 sys_clk = ~sys_clk;

	ddc_ctrl #(.INIT_WAIT_CYC(20)) ddc_ctrl_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ddr_ck(ck), .ddr_ck_n(ck_n), .ddr_cke(cke), .ddr_pins(pins), .ddr_dq_i(dq_i), .ddr_dq_o(dq_o),
		.ddr_dq_oe(dq_oe), .ddr_dm(dm), .ddr_dqs_i(dqs_i), .ddr_dqs_o(dqs_o), .ddr_dqs_oe(dqs_oe));
	ddc_dram_model ddc_dram_model_i (.ck(ck), .cke(cke), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .dm(dm),
		.dqs_o(dqs_o), .dqs_oe(dqs_oe), .dq_i(dq_i), .dqs_i(dqs_i));

	// ----------------------------------------------------------------
	// compare, bus and closing tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] ev, input logic [31:0] got);
		comparisons++;
		if (got !== ev) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, ev, got);
		end
	endtask
	task automatic check_pins(input string what, input ddc_pins_t ev, input ddc_pins_t got);
		comparisons++;
		if (got !== ev) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, ev, got);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// bounded wait on one status bit; exhaustion ends the run
	task automatic poll(input int bitn, input logic val);
		for (int n = 0; n < 3000; n++) begin
			rd(OFS_STATUS, rv);
			if (rv[bitn] === val)
				return;
		end
		check("status wait", 32'(val), 32'(rv[bitn]));
		wrap_up();
	endtask
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic ap, input logic [12:0] ad);
		wr(OFS_ADDR, {19'h0, ad});
		wr(OFS_CMD, {25'h0, ap, b, c});
		poll(1, 1'b0);
		repeat (12) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h91a1_0cc6));
		mode_v = 13'($urandom) & 13'h1e7f;
		emode_v = 13'($urandom) & 13'h0043;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wr(OFS_MODE, {19'h0, mode_v});
		wr(OFS_EMODE, {19'h0, emode_v});
		check("cke in power-up", 32'h0, 32'(cke));
		poll(0, 1'b1);
		exp_a = '{'{P_PRE, 2'h0, 13'h0400}, '{P_MRS, 2'h1, emode_v}, '{P_MRS, 2'h0, mode_v | 13'h0100},
			'{P_PRE, 2'h0, 13'h0400}, '{P_REF, 2'h0, 13'h0000}, '{P_REF, 2'h0, 13'h0000}, '{P_MRS, 2'h0, mode_v}};
		check("init count", 32'h0000_0007, 32'(ddc_dram_model_i.log_q.size()));
		for (idx = 0; idx < 7; idx++) begin
			pv = ddc_dram_model_i.log_q[idx];
			if (pv.ctl != P_MRS) pv.ba = 2'h0;
			if (pv.ctl == P_REF) pv.a = 13'h0000;
			if (pv.ctl == P_PRE) pv.a = pv.a & 13'h0400;
			check_pins("init command", exp_a[idx], pv);
		end
		$display("test init done");

		bank = 2'($urandom);
		row = 13'($urandom);
		wdat = $urandom;
		wmsk = 4'($urandom);
		cmd(C_ACT, bank, 1'b0, row);
		check_pins("activate", '{P_ACT, bank, row}, ddc_dram_model_i.log_q[$]);
		rd(OFS_STATUS, rv);
		check("open banks", 32'(4'h1 << bank), 32'(rv[11:8]));
		wr(OFS_WDATA, wdat);
		wr(OFS_WMASK, {28'h0, wmsk});
		cmd(C_WR, bank, 1'b0, 13'h0000);
		e0 = {wmsk[1] ? 8'h00 : wdat[15:8], wmsk[0] ? 8'h00 : wdat[7:0]};
		e1 = {wmsk[3] ? 8'h00 : wdat[31:24], wmsk[2] ? 8'h00 : wdat[23:16]};
		check("stored beats", {e1, e0}, {ddc_dram_model_i.mem[bank][1], ddc_dram_model_i.mem[bank][0]});
		check("write bus released", 32'h0, 32'({dq_oe, dqs_oe, dm}));
		check("clock pair", 32'h1, 32'(ck ^ ck_n));
		cmd(C_RD, bank, 1'b0, 13'h0000);
		poll(ST_RDONE, 1'b1);
		rd(OFS_RDATA, rv);
		check("read data", {e1, e0}, rv);
		$display("test write read done");

		// refused commands must leave the pins at no-operation
		for (idx = 0; idx < 3; idx++) begin
			wr(OFS_STATUS, 32'h0000_0024);
			n0 = ddc_dram_model_i.log_q.size();
			cmd(bad[idx], bank, 1'b0, 13'h0000);
			rd(OFS_STATUS, rv);
			check("refusal flag", 32'h1, 32'(rv[ST_ERR]));
			check("refused pins", 32'(n0), 32'(ddc_dram_model_i.log_q.size()));
		end
		wr(OFS_STATUS, 32'h0000_0004);
		cmd(C_BST, 2'h0, 1'b0, 13'h0000);
		check("burst stop", 32'(P_BST), 32'(ddc_dram_model_i.log_q[$].ctl));
		cmd(C_PRE, bank + 2'h1, 1'b1, 13'h0000);
		check("pre all pin", 32'h1, 32'(ddc_dram_model_i.log_q[$].a[AP_BIT]));
		check("banks closed", 32'h0, 32'(ddc_dram_model_i.open_q));
		cmd(C_REF, 2'h0, 1'b0, 13'h0000);
		check("refresh", 32'(P_REF), 32'(ddc_dram_model_i.log_q[$].ctl));
		$display("test commands done");

		cmd(C_PD, 2'h0, 1'b0, 13'h0000);
		check("power-down", 32'h1, 32'({cke, ddc_dram_model_i.pd}));
		cmd(C_EXIT, 2'h0, 1'b0, 13'h0000);
		check("power-down exit", 32'h2, 32'({cke, ddc_dram_model_i.pd}));
		cmd(C_SREF, 2'h0, 1'b0, 13'h0000);
		check("self refresh", 32'h1, 32'({cke, ddc_dram_model_i.sr}));
		cmd(C_EXIT, 2'h0, 1'b0, 13'h0000);
		check("self refresh exit", 32'h2, 32'({cke, ddc_dram_model_i.sr}));
		cmd(C_ACT, bank, 1'b0, row);
		check("act after exit", 32'(P_ACT), 32'(ddc_dram_model_i.log_q[$].ctl));
		cmd(C_WR, bank, 1'b1, 13'h0000);
		rd(OFS_STATUS, rv);
		check("auto precharge closes", 32'h0, 32'(rv[11:8]));
		cmd(C_ACT, bank, 1'b0, row);
		check("act after auto precharge", 32'(P_ACT), 32'(ddc_dram_model_i.log_q[$].ctl));
		// clock enable low must freeze the link clock
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(posedge sys_clk);
		#1 n0 = int'(ck);
		repeat (6) @(posedge sys_clk);
		#1 check("frozen link clock", 32'(n0), 32'(ck));
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rd(8'hf0, rv);
		check("unmapped read", 32'h0, rv);
		check("device timing faults", 32'h0, 32'(ddc_dram_model_i.viol));
		$display("test power modes done");
		wrap_up();
	end
endmodule // ddc_ctrl_tb_top
`default_nettype wire
